// ### logic/pbab_pkg.sv
// package of types and constants for the peripheral bus access bridge
package pbab_pkg;

  // ----------------------------------------------------------------------
  // access cost constants
  // ----------------------------------------------------------------------
  localparam logic [1:0] PBAB_SYS_ACCESS_CYCLES = 2'h3; // system core clocks
  localparam logic [1:0] PBAB_MAIN_BUS_CYCLES   = 2'h1; // the acceptance cycle
  localparam logic [2:0] PBAB_PBUS_FIRST_SYNC   = 3'h2; // buses 2..6 sync
  localparam logic [2:0] PBAB_PBUS_LAST         = 3'h6;
  localparam int         PBAB_PBUS_COUNT        = 6;
  localparam logic [1:0] PBAB_CNT_RESET         = 2'h0;
  localparam logic [31:0] PBAB_DATA_RESET       = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  // class of the register behind an address, from the address decoder
  typedef enum logic [1:0] {
    PBAB_TGT_SYS,   // system control registers
    PBAB_TGT_PBUS,  // peripheral bus 1..6
    PBAB_TGT_EXT,   // external bus control unit registers
    PBAB_TGT_BERR   // bus error related registers
  } pbab_tgt_t;

  typedef enum {
    PBAB_ST_IDLE,
    PBAB_ST_SYNC,
    PBAB_ST_PACC,
    PBAB_ST_SYS
  } pbab_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        write;
    pbab_tgt_t   tgt;
    logic [2:0]  pbus;   // peripheral bus number 1..6
  } pbab_req_t;

  localparam pbab_req_t PBAB_REQ_RESET = '0;

endpackage

// ### logic/pbab_bridge.sv
// main bus to peripheral bus access bridge with clock synchronisation
`timescale 1ns/10ps
`default_nettype none

module pbab_bridge (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // main bus side
  input  wire logic                 mb_req_valid,
  input  wire pbab_pkg::pbab_req_t  mb_req,
  input  wire logic                 mb_contend,
  output logic                      mb_busy_q,
  output logic                      mb_done_q,
  output logic [31:0]               mb_rdata_q,
  // clock ratio and slow clock edges
  input  wire logic                 sys_ge_per,
  input  wire logic                 per_tick,
  input  wire logic                 ext_tick,
  // peripheral bus side
  output logic                      pb_valid_q,
  output pbab_pkg::pbab_req_t       pb_req_q,
  output logic [5:0]                pb_sel_q,
  output logic                      ext_sel_q,
  input  wire logic                 pb_ack,
  input  wire logic [31:0]          pb_rdata,
  // system control register side
  output logic                      sys_valid_q,
  input  wire logic [31:0]          sys_rdata
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  pbab_pkg::pbab_state_t st_q, st_d;
  pbab_pkg::pbab_req_t   req_d;
  logic [1:0]            cnt_q, cnt_d;
  logic                  busy_d, done_d, pbv_d, sysv_d, ext_d;
  logic [31:0]           rdata_d;
  logic [5:0]            sel_d;
  logic                  acc, sync_go, needs_sync;

  // a request is taken only while idle, quiet and not on the done beat
  assign acc = mb_req_valid && !mb_contend && !mb_done_q &&
               (st_q == pbab_pkg::PBAB_ST_IDLE);

  // bus error registers and bus 1 skip synchronisation
  assign needs_sync =
    (mb_req.tgt == pbab_pkg::PBAB_TGT_EXT) ||
    ((mb_req.tgt == pbab_pkg::PBAB_TGT_PBUS) &&
     (mb_req.pbus >= pbab_pkg::PBAB_PBUS_FIRST_SYNC));

  // sync ends on the next slow edge; with a slower core clock the peripheral buses need no wait
  always_comb begin
    if (pb_req_q.tgt == pbab_pkg::PBAB_TGT_EXT) begin
      sync_go = ext_tick;
    end else if (sys_ge_per) begin
      sync_go = per_tick;
    end else begin
      sync_go = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    req_d   = pb_req_q;
    busy_d  = mb_busy_q;
    done_d  = 1'b0;
    rdata_d = mb_rdata_q;
    pbv_d   = pb_valid_q;
    sysv_d  = 1'b0;
    case (st_q)
      pbab_pkg::PBAB_ST_IDLE: begin
        if (acc) begin
          req_d  = mb_req;
          busy_d = 1'b1;
          if (mb_req.tgt == pbab_pkg::PBAB_TGT_SYS) begin
            st_d   = pbab_pkg::PBAB_ST_SYS;
            cnt_d  = pbab_pkg::PBAB_MAIN_BUS_CYCLES;
            sysv_d = 1'b1;
          end else if (needs_sync) begin
            st_d = pbab_pkg::PBAB_ST_SYNC;
          end else begin
            st_d  = pbab_pkg::PBAB_ST_PACC;
            pbv_d = 1'b1;
          end
        end
      end
      pbab_pkg::PBAB_ST_SYNC: begin
        if (sync_go) begin
          st_d  = pbab_pkg::PBAB_ST_PACC;
          pbv_d = 1'b1;
        end
      end
      pbab_pkg::PBAB_ST_PACC: begin
        // length set by the addressed register, not by this bridge
        if (pb_ack) begin
          st_d    = pbab_pkg::PBAB_ST_IDLE;
          pbv_d   = 1'b0;
          busy_d  = 1'b0;
          done_d  = 1'b1;
          rdata_d = pb_req_q.write ? pbab_pkg::PBAB_DATA_RESET : pb_rdata;
        end
      end
      pbab_pkg::PBAB_ST_SYS: begin
        // fixed cost whatever the peripheral clock ratio
        if (cnt_q == pbab_pkg::PBAB_SYS_ACCESS_CYCLES - 2'h1) begin
          st_d    = pbab_pkg::PBAB_ST_IDLE;
          cnt_d   = pbab_pkg::PBAB_CNT_RESET;
          busy_d  = 1'b0;
          done_d  = 1'b1;
          rdata_d = pb_req_q.write ? pbab_pkg::PBAB_DATA_RESET : sys_rdata;
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      default: begin
        st_d = pbab_pkg::PBAB_ST_IDLE;
      end
    endcase
  end

  // one select line per peripheral bus, plus the external unit
  genvar gi;
  generate
    for (gi = 0; gi < pbab_pkg::PBAB_PBUS_COUNT; gi++) begin : g_sel
      assign sel_d[gi] = pbv_d &&
                         (req_d.tgt == pbab_pkg::PBAB_TGT_PBUS) &&
                         (req_d.pbus == 3'(gi + 1));
    end
  endgenerate
  assign ext_d = pbv_d && ((req_d.tgt == pbab_pkg::PBAB_TGT_EXT) ||
                           (req_d.tgt == pbab_pkg::PBAB_TGT_BERR));

  // ----------------------------------------------------------------------
  // registers; clock enable low freezes everything
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= pbab_pkg::PBAB_ST_IDLE;
      cnt_q       <= pbab_pkg::PBAB_CNT_RESET;
      pb_req_q    <= pbab_pkg::PBAB_REQ_RESET;
      mb_busy_q   <= 1'b0;
      mb_done_q   <= 1'b0;
      mb_rdata_q  <= pbab_pkg::PBAB_DATA_RESET;
      pb_valid_q  <= 1'b0;
      pb_sel_q    <= 6'h00;
      ext_sel_q   <= 1'b0;
      sys_valid_q <= 1'b0;
    end else if (clk_en) begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      pb_req_q    <= req_d;
      mb_busy_q   <= busy_d;
      mb_done_q   <= done_d;
      mb_rdata_q  <= rdata_d;
      pb_valid_q  <= pbv_d;
      pb_sel_q    <= sel_d;
      ext_sel_q   <= ext_d;
      sys_valid_q <= sysv_d;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic acc_sys, acc_b1;
  assign acc_sys = acc && clk_en &&
                   (mb_req.tgt == pbab_pkg::PBAB_TGT_SYS);
  assign acc_b1  = acc && clk_en &&
                   (mb_req.tgt == pbab_pkg::PBAB_TGT_PBUS) &&
                   (mb_req.pbus == 3'h1);

  sequence s_sys_run;
    acc_sys ##1 clk_en [*2];
  endsequence
  sequence s_pb_end;
    pb_valid_q && pb_ack && clk_en;
  endsequence

  chk_sys_three_cycles: assert property (
    s_sys_run |=> mb_done_q && !mb_busy_q)
    else $error("system register access not done in three cycles");
  chk_sys_no_early: assert property (
    acc_sys |=> !mb_done_q ##1 (!mb_done_q || !clk_en))
    else $error("system register access finished too early");
  chk_bus1_direct: assert property (
    acc_b1 |=> pb_valid_q && pb_sel_q[0])
    else $error("bus 1 access waited for synchronisation");
  chk_sync_wait_edge: assert property (
    (st_q == pbab_pkg::PBAB_ST_SYNC) && sys_ge_per && !per_tick &&
    clk_en && (pb_req_q.tgt == pbab_pkg::PBAB_TGT_PBUS)
    |=> !pb_valid_q)
    else $error("peripheral access issued before clock edge");
  chk_sync_on_edge: assert property (
    (st_q == pbab_pkg::PBAB_ST_SYNC) && clk_en && sync_go
    |=> pb_valid_q)
    else $error("sync did not end on the slow clock edge");
  chk_ext_on_bclk: assert property (
    (st_q == pbab_pkg::PBAB_ST_SYNC) && ext_tick && clk_en &&
    (pb_req_q.tgt == pbab_pkg::PBAB_TGT_EXT) |=> pb_valid_q && ext_sel_q)
    else $error("external unit access missed its clock edge");
  chk_slow_core_go: assert property (
    (st_q == pbab_pkg::PBAB_ST_SYNC) && !sys_ge_per && clk_en &&
    (pb_req_q.tgt == pbab_pkg::PBAB_TGT_PBUS) |=> pb_valid_q)
    else $error("slow core clock access was delayed");
  chk_hold_wait: assert property (
    pb_valid_q && !(pb_ack && clk_en) |=> pb_valid_q && mb_busy_q &&
    !mb_done_q)
    else $error("master released before peripheral ack");
  chk_ack_done: assert property (
    s_pb_end |=> mb_done_q && !pb_valid_q && !mb_busy_q)
    else $error("peripheral ack did not complete the access");
  chk_read_data: assert property (
    (s_pb_end and !pb_req_q.write) |=> mb_rdata_q == $past(pb_rdata))
    else $error("read data not returned from peripheral bus");
  chk_contend_block: assert property (
    (st_q == pbab_pkg::PBAB_ST_IDLE) && mb_contend && !mb_busy_q
    |=> !mb_busy_q)
    else $error("request taken during bus contention");

endmodule

`default_nettype wire

// ### verification/pbab_periph_model.sv
// peripheral bus and system register side model for the bridge bench
`timescale 1ns/10ps
`default_nettype none

module pbab_periph_model (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [3:0]          ack_wait,
  input  wire logic                pb_valid_q,
  input  wire pbab_pkg::pbab_req_t pb_req_q,
  input  wire logic                sys_valid_q,
  output logic                     pb_ack,
  output logic [31:0]              pb_rdata,
  output logic [31:0]              sys_rdata
);
  logic [3:0]  wait_q;
  logic        sys_q;
  logic [31:0] junk_q;

  // wait counter per access; junk changes every cycle so stale data fails
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      sys_q  <= 1'b0;
      junk_q <= 32'h1357_9bdf;
    end else begin
      wait_q <= (pb_valid_q && !pb_ack) ? wait_q + 4'h1 : 4'h0;
      sys_q  <= sys_valid_q;
      junk_q <= {junk_q[30:0], ~junk_q[31]};
    end
  end

  // answer after a wait chosen by the bench for each access
  assign pb_ack    = pb_valid_q && (wait_q == ack_wait);
  assign pb_rdata  = pb_ack ? (pb_req_q.addr ^ 32'h0f0f_f0f0) : junk_q;
  // data only in the cycle the bridge samples it
  assign sys_rdata = sys_q ? (pb_req_q.addr ^ 32'h5a5a_0000) : junk_q;
endmodule

`default_nettype wire

// ### verification/peripheral_bus_access_bridge_tb.sv
// self-checking bench for the peripheral bus access bridge
`timescale 1ns/10ps
`default_nettype none

module peripheral_bus_access_bridge_tb;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  logic                clk_en = 1'b1;
  logic                mb_req_valid = 1'b0;
  pbab_pkg::pbab_req_t mb_req = '0;
  logic                mb_contend = 1'b0;
  logic                sys_ge_per = 1'b1;
  logic                per_tick = 1'b0;
  logic                ext_tick = 1'b0;
  logic [3:0]          ack_wait = 4'h0;
  logic                mb_busy_q, mb_done_q, pb_valid_q, pb_ack;
  logic                ext_sel_q, sys_valid_q;
  logic [31:0]         mb_rdata_q, pb_rdata, sys_rdata;
  logic [5:0]          pb_sel_q;
  pbab_pkg::pbab_req_t pb_req_q;
  int                  n_fail = 0;
  int                  total_checks = 0;

  always #5 clock = ~clock;

  pbab_bridge i_pbab_bridge (.clock, .rst_n, .clk_en, .mb_req_valid,
    .mb_req, .mb_contend, .mb_busy_q, .mb_done_q, .mb_rdata_q,
    .sys_ge_per, .per_tick, .ext_tick, .pb_valid_q, .pb_req_q, .pb_sel_q,
    .ext_sel_q, .pb_ack, .pb_rdata, .sys_valid_q, .sys_rdata);

  pbab_periph_model i_pbab_periph_model (.clock, .rst_n, .ack_wait,
    .pb_valid_q, .pb_req_q, .sys_valid_q, .pb_ack, .pb_rdata, .sys_rdata);

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one access: k = tick slot, d = ack wait, c = refused cycles,
  // lat = edges from acceptance to completion
  // each call moves one word, never a repeated or string operand
  task automatic access(input pbab_pkg::pbab_tgt_t tgt, input logic [2:0] bus,
      input logic wr, input logic ge, input int k, input int d, input int c,
      input int lat);
    int          n;
    logic        seen;
    logic [31:0] a;
    logic [31:0] exp;
    logic        is_sys;
    a = {13'h0101, bus, 16'(lat)};
    n = 0;
    seen = 1'b0;
    is_sys = (tgt == pbab_pkg::PBAB_TGT_SYS);
    @(negedge clock);
    sys_ge_per = ge;
    ack_wait = 4'(d);
    mb_req = '{a, ~a, 4'hf, wr, tgt, bus};
    mb_req_valid = 1'b1;
    mb_contend = (c > 0);
    while (mb_done_q !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
      mb_contend = (n < c);
      per_tick = (n == k + c) && tgt == pbab_pkg::PBAB_TGT_PBUS;
      ext_tick = (n == k + c) && tgt == pbab_pkg::PBAB_TGT_EXT;
      if (n <= c) check("busy while refused", 32'h0, mb_busy_q);
      if (n == c + 1 && lat > 1)
        check("wait state", 32'h1, mb_busy_q);
      if (n == c + 1) check("system strobe", is_sys, sys_valid_q);
      if (pb_valid_q === 1'b1 && !seen) begin
        seen = 1'b1;
        exp = (tgt == pbab_pkg::PBAB_TGT_PBUS) ?
              {26'h0, 6'h01 << (bus - 3'h1)} : 32'h40;
        check("bus select", exp, {ext_sel_q, pb_sel_q});
        check("request address", a, pb_req_q.addr);
        check("request data", ~a, pb_req_q.wdata);
        check("request write", wr, pb_req_q.write);
      end
    end
    check("access cycles", c + lat, n);
    check("peripheral use", tgt != pbab_pkg::PBAB_TGT_SYS, seen);
    check("busy at done", 32'h0, mb_busy_q);
    exp = wr ? 32'h0 : a ^ ((tgt == pbab_pkg::PBAB_TGT_SYS) ?
          32'h5a5a_0000 : 32'h0f0f_f0f0);
    check("read data", exp, mb_rdata_q);
    // valid still up across the done beat: that edge must refuse it
    @(negedge clock);
    check("done one cycle", 32'h0, mb_done_q);
    check("refused on done", 32'h0, mb_busy_q);
    mb_req_valid = 1'b0;
    per_tick = 1'b0;
    ext_tick = 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_system();
    access(pbab_pkg::PBAB_TGT_SYS, 3'h0, 1'b0, 1'b1, 0, 0, 0, 3);
    // system register write with the core clock slower, same three cycles
    access(pbab_pkg::PBAB_TGT_SYS, 3'h0, 1'b1, 1'b0, 0, 0, 0, 3);
    $display("end of system register test");
  endtask

  task automatic t_bus_one();
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h1, 1'b0, 1'b1, 0, 0, 0, 2);
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h1, 1'b1, 1'b1, 0, 5, 0, 7);
    $display("end of peripheral bus one test");
  endtask

  // buses 2..6 with the core clock faster: sync ends on a slow tick
  task automatic t_sync_fast();
    for (int b = 2; b <= 6; b++)
      access(pbab_pkg::PBAB_TGT_PBUS, 3'(b), 1'b0, 1'b1, b - 1, 1, 0,
             b + 2);
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h6, 1'b1, 1'b1, 4, 0, 0, 6);
    $display("end of fast core sync test");
  endtask

  task automatic t_sync_slow();
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h2, 1'b0, 1'b0, 0, 0, 0, 3);
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h4, 1'b0, 1'b0, 0, 2, 0, 5);
    $display("end of slow core sync test");
  endtask

  task automatic t_ext_berr();
    access(pbab_pkg::PBAB_TGT_EXT, 3'h0, 1'b0, 1'b1, 3, 0, 0, 5);
    access(pbab_pkg::PBAB_TGT_BERR, 3'h0, 1'b0, 1'b1, 0, 0, 0, 2);
    $display("end of external control test");
  endtask

  task automatic t_contend();
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h1, 1'b0, 1'b1, 0, 0, 3, 2);
    $display("end of contention test");
  endtask

  // two writes, then a read of only the last one's address; the model stores no write data
  task automatic t_readback();
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h3, 1'b1, 1'b1, 2, 0, 0, 4);
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h5, 1'b1, 1'b1, 4, 0, 0, 6);
    access(pbab_pkg::PBAB_TGT_PBUS, 3'h5, 1'b0, 1'b1, 4, 0, 0, 6);
    $display("end of write readback test");
  endtask

  // clock enable low in mid-access: state holds, then the access resumes
  task automatic t_freeze();
    logic [31:0] a;
    a = 32'h0101_7e03;
    @(negedge clock);
    mb_req = '{a, ~a, 4'hf, 1'b0, pbab_pkg::PBAB_TGT_SYS, 3'h0};
    mb_req_valid = 1'b1;
    @(negedge clock);
    clk_en = 1'b0;
    repeat (2) @(negedge clock);
    check("frozen strobe", 32'h1, sys_valid_q);
    check("frozen busy", 32'h1, mb_busy_q);
    clk_en = 1'b1;
    @(negedge clock);
    check("no done after thaw", 32'h0, mb_done_q);
    @(negedge clock);
    check("done after thaw", 32'h1, mb_done_q);
    check("thaw read data", a ^ 32'h5a5a_0000, mb_rdata_q);
    mb_req_valid = 1'b0;
    $display("end of clock enable test");
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    t_system();
    t_bus_one();
    t_sync_fast();
    t_sync_slow();
    t_ext_berr();
    t_contend();
    t_readback();
    t_freeze();
    conclude();
  end

  // the tests need about 140 cycles; this cuts a hang short
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    conclude();
  end
endmodule

`default_nettype wire
